// ### dbad_pkg.sv
// Shared constants for the board address decoder: region bounds, wait counts.
// Assumes a 24-bit word address from the processor's external bus.
package dbad_pkg;
   // ==========================================================
   // Region bounds (word addresses)
   localparam logic [23:0] BOOT_HI     = 24'h000FFF;
   localparam logic [23:0] XRAM_LO     = 24'h001000;
   localparam logic [23:0] XRAM_HI     = 24'h03FFFF;
   localparam logic [23:0] FLASH_LO    = 24'h400000;
   localparam logic [23:0] FLASH_HI    = 24'h47FFFF;
   localparam logic [23:0] IRAM2_LO    = 24'h800000;
   localparam logic [23:0] IRAM3_LO    = 24'h804000;
   localparam logic [23:0] IRAM3_HI    = 24'h807FFF;
   localparam logic [23:0] PERIPH_LO   = 24'h808000;
   localparam logic [23:0] PERIPH_HI   = 24'h8097FF;
   localparam logic [23:0] IRAM0_LO    = 24'h809800;
   localparam logic [23:0] IRAM1_LO    = 24'h809C00;
   localparam logic [23:0] IRAM1_HI    = 24'h809FFF;
   localparam logic [23:0] VECTOR_LO   = 24'h809FC1;
   localparam logic [23:0] SWLED_ADDR  = 24'h80B005;
   // ==========================================================
   // Wait states per region
   localparam logic [2:0]  XRAM_WAITS  = 3'h5;
   localparam logic [2:0]  FLASH_WAITS = 3'h7;
   localparam logic [2:0]  NO_WAITS    = 3'h0;
   // ==========================================================
   // Reset values
   localparam logic [7:0]  LED_RST     = 8'h00;
   localparam logic [7:0]  SW_RST      = 8'h00;
   // Decoded region codes
   typedef enum logic [2:0] {
      DBAD_RG_NONE   = 3'b000,
      DBAD_RG_BOOT   = 3'b001,
      DBAD_RG_XRAM   = 3'b010,
      DBAD_RG_FLASH  = 3'b011,
      DBAD_RG_IRAM   = 3'b100,
      DBAD_RG_PERIPH = 3'b101,
      DBAD_RG_SWLED  = 3'b110
   } dbad_region_t;
endpackage

// ### dbad_dec_if.sv
// Interface carrying the decoded region between decoder and top.
// Assumes dbad_pkg compiled first.
`timescale 1ns/100ps
interface dbad_dec_if;
   logic [23:0]           addr;
   dbad_pkg::dbad_region_t region;
   logic [2:0]            waits;
   logic                  vector_hit;
   modport dec (input addr, output region, output waits, output vector_hit);
   modport top (output addr, input region, input waits, input vector_hit);
endinterface

// ### dbad_region_dec.sv
// Combinational address-range decoder with per-region wait count.
// Assumes the address is stable in the strobe cycle of an access.
`timescale 1ns/100ps
module dbad_region_dec (
   // Decode port
   dbad_dec_if.dec d
);
   // ==========================================================
   // Range compare
   always_comb begin
      d.region     = dbad_pkg::DBAD_RG_NONE;
      d.waits      = dbad_pkg::NO_WAITS;     // R09
      d.vector_hit = 1'b0;
      if (d.addr <= dbad_pkg::BOOT_HI) begin
         d.region = dbad_pkg::DBAD_RG_BOOT;  // R01
      end else if (d.addr >= dbad_pkg::XRAM_LO && d.addr <= dbad_pkg::XRAM_HI) begin
         d.region = dbad_pkg::DBAD_RG_XRAM;  // R02
         d.waits  = dbad_pkg::XRAM_WAITS;
      end else if (d.addr >= dbad_pkg::FLASH_LO && d.addr <= dbad_pkg::FLASH_HI) begin
         d.region = dbad_pkg::DBAD_RG_FLASH; // R03
         d.waits  = dbad_pkg::FLASH_WAITS;
      end else if (d.addr >= dbad_pkg::IRAM2_LO && d.addr <= dbad_pkg::IRAM3_HI) begin
         d.region = dbad_pkg::DBAD_RG_IRAM;  // R06
      end else if (d.addr >= dbad_pkg::PERIPH_LO && d.addr <= dbad_pkg::PERIPH_HI) begin
         d.region = dbad_pkg::DBAD_RG_PERIPH; // R07
      end else if (d.addr >= dbad_pkg::IRAM0_LO && d.addr <= dbad_pkg::IRAM1_HI) begin
         d.region     = dbad_pkg::DBAD_RG_IRAM; // R08
         d.vector_hit = (d.addr >= dbad_pkg::VECTOR_LO);
      end else if (d.addr == dbad_pkg::SWLED_ADDR) begin
         d.region = dbad_pkg::DBAD_RG_SWLED;
      end
   end
endmodule

// ### dbad_top.sv
// Board address decoder and wait-state generator for the DSP external bus.
// Assumes a one-cycle strobe starts each access and address/data hold until ready.
// Functional notes
// [R01] Addresses 0h to FFFh stay for the bootloader; no external select.
// [R02] External RAM at 1000h..3FFFFh, five wait states per access.
// [R03] Flash at 400000h..47FFFFh, seven wait states per access.
// [R04] Flash uses data bits 7..0 only; upper 24 bits untouched.
// [R05] On-chip RAM, 136 KB, reached with zero wait states.
// [R06] 800000h..807FFFh map to two internal 64 KB blocks.
// [R07] 808000h..8097FFh belong to internal peripherals; decoder stays off.
// [R08] 809800h..809FFFh are two 4 KB blocks; top holds branch table.
// [R09] Empty regions select nothing and finish without wait states.
// [R10] LED write lights LEDs for 1 bits, echoed on expansion outputs.
// [R11] Switch read returns eight switches, shared with expansion inputs.
`timescale 1ns/100ps
module dbad_top (
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_n_i,
   // Processor bus
   input  wire logic        strb_i,
   input  wire logic        rd_wr_i,
   input  wire logic [23:0] addr_i,
   input  wire logic [31:0] wdata_i,
   output logic [31:0]      rdata_o,
   output logic             ready_o,
   // Memory selects
   output logic             xram_sel_o,
   output logic             flash_sel_o,
   output logic             iram_sel_o,
   output logic             vector_sel_o,
   // Flash byte lane
   input  wire logic [7:0]  flash_rdata_i,
   output logic [7:0]       flash_wdata_o,
   output logic             flash_we_o,
   // External RAM data
   input  wire logic [31:0] xram_rdata_i,
   // Switches and LEDs
   input  wire logic [7:0]  switch_i,
   output logic [7:0]       led_o,
   output logic [7:0]       exp_out_o
);
   // ==========================================================
   // Access state
   typedef enum logic [1:0] {
      DBAD_IDLE = 2'b00,
      DBAD_WAIT = 2'b01,
      DBAD_DONE = 2'b10
   } dbad_state_t;

   // Decoder carrier and sequencer state
   dbad_dec_if             dec ();
   dbad_state_t            state_r,   state_nxt;
   dbad_pkg::dbad_region_t region_r,  region_nxt;
   logic [2:0]             cnt_r,     cnt_nxt;
   logic                   wr_r,      wr_nxt;
   logic                   vec_r,     vec_nxt;
   logic                   complete;
   // Result and port state
   logic [7:0]             led_r,     led_nxt;
   logic [31:0]            rdata_r,   rdata_nxt;
   logic [7:0]             fwd_r,     fwd_nxt;
   // Accepted switch levels, one bit from each synchroniser slice
   logic [7:0]             sw_sync;

   // ==========================================================
   // Region decoder, purely combinational on the held address
   assign dec.addr = addr_i;

   dbad_region_dec u_dec (
      .d (dec.dec)
   );

   // ==========================================================
   // Switch synchroniser, one slice per switch bit
   // The switches and the expansion inputs come straight off the board with
   // no relation to this clock; a bit is accepted only once stages two and
   // three agree, so a level that moves at a clock edge is never half taken.
   for (genvar g = 0; g < 8; g++) begin : g_sw
      logic s1_r,  s1_nxt;
      logic s2_r,  s2_nxt;
      logic s3_r,  s3_nxt;
      logic acc_r, acc_nxt;

      // Shift the pin in; hold the accepted level while stages two and three differ
      always_comb begin
         s1_nxt  = switch_i[g];
         s2_nxt  = s1_r;
         s3_nxt  = s2_r;
         acc_nxt = (s2_r == s3_r) ? s3_r : acc_r;   // R11
      end

      // Stage registers only
      always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            s1_r  <= dbad_pkg::SW_RST[g];
            s2_r  <= dbad_pkg::SW_RST[g];
            s3_r  <= dbad_pkg::SW_RST[g];
            acc_r <= dbad_pkg::SW_RST[g];
         end else begin
            s1_r  <= s1_nxt;
            s2_r  <= s2_nxt;
            s3_r  <= s3_nxt;
            acc_r <= acc_nxt;
         end
      end

      assign sw_sync[g] = acc_r;
   end

   // ==========================================================
   // Access sequencer; wait count loads from the region decode
   // Edges after the strobe edge until ready is seen: one for internal RAM,
   // ports and empty space, six for external RAM, eight for flash.
   // A strobe that arrives while an access runs is dropped without trace,
   // so the processor must wait for ready before it strobes again.
   always_comb begin
      state_nxt  = state_r;
      region_nxt = region_r;
      cnt_nxt    = cnt_r;
      wr_nxt     = wr_r;
      vec_nxt    = vec_r;
      complete   = 1'b0;
      case (state_r)
         DBAD_IDLE: begin
            if (strb_i) begin
               region_nxt = dec.region;
               vec_nxt    = dec.vector_hit;
               wr_nxt     = !rd_wr_i;
               cnt_nxt    = dec.waits;
               // Zero-wait regions finish at once (internal RAM, empty, ports)
               state_nxt  = (dec.waits == dbad_pkg::NO_WAITS) ? DBAD_DONE : DBAD_WAIT; // R05 R09
            end
         end
         DBAD_WAIT: begin
            cnt_nxt = cnt_r - 3'h1;               // R02 R03
            if (cnt_r == 3'h1) begin
               state_nxt = DBAD_DONE;
            end
         end
         DBAD_DONE: begin
            complete  = 1'b1;
            state_nxt = DBAD_IDLE;
         end
         default: begin
            state_nxt = DBAD_IDLE;
         end
      endcase
   end

   // Sequencer registers only
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r  <= DBAD_IDLE;
         region_r <= dbad_pkg::DBAD_RG_NONE;
         cnt_r    <= dbad_pkg::NO_WAITS;
         wr_r     <= 1'b0;
         vec_r    <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         region_r <= region_nxt;
         cnt_r    <= cnt_nxt;
         wr_r     <= wr_nxt;
         vec_r    <= vec_nxt;
      end
   end

   // ==========================================================
   // Result registers: read data, flash write byte and LED port
   // The LED port only moves on a write to its own location, so reads of the
   // switches and accesses elsewhere never disturb what the LEDs show.
   always_comb begin
      rdata_nxt = rdata_r;
      led_nxt   = led_r;
      fwd_nxt   = fwd_r;
      // Flash byte is caught with the strobe and stands through the access
      if (state_r == DBAD_IDLE && strb_i) begin
         fwd_nxt = wdata_i[7:0];                 // R04
      end
      if (complete) begin
         case (region_r)
            dbad_pkg::DBAD_RG_XRAM:  rdata_nxt = xram_rdata_i;
            dbad_pkg::DBAD_RG_FLASH: rdata_nxt = {24'h000000, flash_rdata_i}; // R04
            dbad_pkg::DBAD_RG_SWLED: rdata_nxt = {24'h000000, sw_sync};       // R11
            default:                 rdata_nxt = 32'h00000000;
         endcase
         if (wr_r && region_r == dbad_pkg::DBAD_RG_SWLED) begin
            led_nxt = wdata_i[7:0];              // R10
         end
      end
   end

   // Result registers only
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         led_r   <= dbad_pkg::LED_RST;
         rdata_r <= 32'h00000000;
         fwd_r   <= 8'h00;
      end else begin
         led_r   <= led_nxt;
         rdata_r <= rdata_nxt;
         fwd_r   <= fwd_nxt;
      end
   end

   // ==========================================================
   // Selects stay up for the whole access; bootloader and peripheral space never select
   // They come from registered state, so they cannot glitch while the address
   // settles; the price is that a memory sees its select one edge after the strobe.
   // The flash write byte is registered too, so it stands unchanged under the write pulse.
   assign xram_sel_o    = (state_r != DBAD_IDLE) && region_r == dbad_pkg::DBAD_RG_XRAM;  // R02
   assign flash_sel_o   = (state_r != DBAD_IDLE) && region_r == dbad_pkg::DBAD_RG_FLASH; // R03
   assign iram_sel_o    = (state_r != DBAD_IDLE) && region_r == dbad_pkg::DBAD_RG_IRAM;  // R06 R08
   assign vector_sel_o  = iram_sel_o && vec_r;   // R08
   assign flash_we_o    = flash_sel_o && wr_r && (state_r == DBAD_DONE);
   assign flash_wdata_o = fwd_r;                 // R04
   assign ready_o       = complete;
   assign rdata_o       = rdata_r;
   assign led_o         = led_r;                 // R10
   assign exp_out_o     = led_r;                 // R10
endmodule

// ### dbad_top_properties.sv
// Checker for the board decoder: access timing, selects, LED port.
// Bound to dbad_top; sees only its ports.
`timescale 1ns/100ps
module dbad_top_properties (
   // Clock, reset and processor bus
   input wire logic        sys_clk_i,
   input wire logic        rst_n_i,
   input wire logic        strb_i,
   input wire logic        rd_wr_i,
   input wire logic [23:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic [31:0] rdata_o,
   input wire logic        ready_o,
   // Selects, flash lane and LEDs
   input wire logic        xram_sel_o,
   input wire logic        flash_sel_o,
   input wire logic        iram_sel_o,
   input wire logic [7:0]  flash_rdata_i,
   input wire logic [7:0]  led_o,
   input wire logic [7:0]  exp_out_o
);
   // ====================
   // A strobe counts only while idle; strobes inside an access are ignored
   logic idle_r;
   logic take;
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) idle_r <= 1'h1;
      else if (ready_o) idle_r <= 1'h1;
      else if (strb_i) idle_r <= 1'h0;
   end
   assign take = strb_i && idle_r;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   // ====================
   // Region timing and selects
   a_boot_quiet: assert property (take && addr_i <= dbad_pkg::BOOT_HI |=> ready_o && !xram_sel_o && !flash_sel_o)
      else $error("boot access not quiet");
   a_xram_five: assert property (take && addr_i inside {[dbad_pkg::XRAM_LO:dbad_pkg::XRAM_HI]}
      |=> (xram_sel_o && !ready_o)[*5] ##1 (xram_sel_o && ready_o)) else $error("xram wait count");
   a_flash_seven: assert property (take && addr_i inside {[dbad_pkg::FLASH_LO:dbad_pkg::FLASH_HI]}
      |=> (flash_sel_o && !ready_o)[*7] ##1 (flash_sel_o && ready_o)) else $error("flash wait count");
   a_flash_lane: assert property (ready_o && flash_sel_o && rd_wr_i |=> rdata_o == {24'h000000, $past(flash_rdata_i)})
      else $error("flash byte lane");
   a_iram_zero: assert property (take && addr_i inside {[24'h800000:24'h807FFF], [24'h809800:24'h809FFF]}
      |=> ready_o && iram_sel_o) else $error("internal ram timing");
   a_periph_off: assert property (take && addr_i inside {[24'h808000:24'h8097FF]}
      |=> ready_o && !iram_sel_o && !xram_sel_o && !flash_sel_o) else $error("peripheral claimed");
   a_empty_fast: assert property (take && addr_i inside {[24'h040000:24'h3FFFFF], [24'h480000:24'h7FFFFF]}
      |=> ready_o && !iram_sel_o && !xram_sel_o && !flash_sel_o) else $error("empty region claimed");
   a_led_write: assert property (take && !rd_wr_i && addr_i == dbad_pkg::SWLED_ADDR
      |=> ##1 led_o == $past(wdata_i[7:0], 2) && exp_out_o == led_o) else $error("led write");
endmodule
bind dbad_top dbad_top_properties chk_u (.sys_clk_i, .rst_n_i, .strb_i, .rd_wr_i, .addr_i, .wdata_i,
   .rdata_o, .ready_o, .xram_sel_o, .flash_sel_o, .iram_sel_o, .flash_rdata_i, .led_o, .exp_out_o);

// ### dbad_mem_model.sv
// External RAM and flash seen from the decoder: data only while selected.
// Unselected parts show a toggling pattern, never a stale value.
`timescale 1ns/100ps
module dbad_mem_model (
   // Clock and selects
   input  wire logic        sys_clk_i,
   input  wire logic        xram_sel_i,
   input  wire logic        flash_sel_i,
   input  wire logic [23:0] addr_i,
   // Read data
   output logic [31:0]      xram_rdata_o,
   output logic [7:0]       flash_rdata_o
);
   logic [7:0] junk_r = 8'h5A;
   // Junk flips every cycle so a missed select cannot pass by luck
   always_ff @(posedge sys_clk_i) junk_r <= ~junk_r;
   assign xram_rdata_o  = xram_sel_i ? {8'hC3, addr_i} : {4{junk_r}};
   assign flash_rdata_o = flash_sel_i ? addr_i[7:0] ^ 8'h3C : junk_r;
endmodule

// ### dbad_top_tb.sv
// Self-checking bench for the board decoder.
// Assumes the memory model answers as the far side of the bus.
`timescale 1ns/100ps
module dbad_top_tb;
   logic        sys_clk_i, rst_n_i, strb_i, rd_wr_i, ready_o, flash_we_o, vector_sel_o;
   logic        xram_sel_o, flash_sel_o, iram_sel_o;
   logic [23:0] addr_i;
   logic [31:0] wdata_i, rdata_o, xram_rdata_i;
   logic [7:0]  flash_rdata_i, flash_wdata_o, switch_i, led_o, exp_out_o;
   int          error_cnt = 0;
   int          tests_run = 0;
   dbad_top dut_u (.sys_clk_i, .rst_n_i, .strb_i, .rd_wr_i, .addr_i, .wdata_i, .rdata_o, .ready_o,
      .xram_sel_o, .flash_sel_o, .iram_sel_o, .vector_sel_o, .flash_rdata_i, .flash_wdata_o,
      .flash_we_o, .xram_rdata_i, .switch_i, .led_o, .exp_out_o);
   dbad_mem_model mem_u (.sys_clk_i, .xram_sel_i(xram_sel_o), .flash_sel_i(flash_sel_o), .addr_i,
      .xram_rdata_o(xram_rdata_i), .flash_rdata_o(flash_rdata_i));
   // ====================
   // Clock, compare and verdict
   initial begin
      sys_clk_i = 1'h0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic results();
      if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // One access: strobe one cycle, hold address and data until ready
   task automatic bus(input logic rd, input logic [23:0] a, input logic [31:0] d, input int w,
                      input logic [2:0] es, input logic [31:0] er);
      int n;
      logic vec;
      logic [4:0] sel;
      @(negedge sys_clk_i);
      strb_i = 1'h1;
      rd_wr_i = rd;
      addr_i = a;
      wdata_i = d;
      @(negedge sys_clk_i);
      strb_i = 1'h0;
      n = 1;
      while (ready_o !== 1'h1 && n < 12) begin
         @(negedge sys_clk_i);
         n++;
      end
      check("wait", 32'(w + 1), 32'(n));
      vec = es[0] && a >= dbad_pkg::VECTOR_LO && a <= dbad_pkg::IRAM1_HI;
      sel = {xram_sel_o, flash_sel_o, iram_sel_o, flash_we_o, vector_sel_o};
      check("sel", {27'h0, es, es[1] & !rd, vec}, {27'h0, sel});
      if (!rd && es[1]) check("flash_wdata", {24'h0, d[7:0]}, {24'h0, flash_wdata_o});
      @(negedge sys_clk_i);
      if (rd) check("rdata", er, rdata_o);
   endtask
   // ====================
   // Scenarios
   task automatic t_quiet();
      bus(1'h1, 24'h000FFF, 32'h0, 0, 3'h0, 32'h0);
      bus(1'h1, 24'h040000, 32'h0, 0, 3'h0, 32'h0);
      bus(1'h0, 24'h480000, 32'h0, 0, 3'h0, 32'h0);
   endtask
   task automatic t_ext();
      bus(1'h1, 24'h001000, 32'h0, 5, 3'h4, 32'hC3001000);
      bus(1'h1, 24'h03FFFF, 32'h0, 5, 3'h4, 32'hC303FFFF);
      bus(1'h1, 24'h400000, 32'h0, 7, 3'h2, 32'h0000003C);
      bus(1'h0, 24'h47FFFF, 32'hFFFFFF5A, 7, 3'h2, 32'h0);
      bus(1'h1, 24'h47FFFF, 32'h0, 7, 3'h2, 32'h000000C3);
   endtask
   task automatic t_iram();
      bus(1'h1, 24'h800000, 32'h0, 0, 3'h1, 32'h0);
      bus(1'h0, 24'h807FFF, 32'h1, 0, 3'h1, 32'h0);
      bus(1'h1, 24'h809800, 32'h0, 0, 3'h1, 32'h0);
      bus(1'h1, 24'h809FFF, 32'h0, 0, 3'h1, 32'h0);
      bus(1'h1, 24'h809FC1, 32'h0, 0, 3'h1, 32'h0);
      bus(1'h0, 24'h809FC0, 32'h0, 0, 3'h1, 32'h0);
      bus(1'h1, 24'h808000, 32'h0, 0, 3'h0, 32'h0);
   endtask
   task automatic t_swled();
      check("led_rst", 32'h0, {16'h0, led_o, exp_out_o});
      bus(1'h0, 24'h80B005, 32'hFFFFFFA5, 0, 3'h0, 32'h0);
      check("led", 32'hA5A5, {16'h0, led_o, exp_out_o});
      switch_i = 8'h96;
      repeat (6) @(negedge sys_clk_i);
      bus(1'h1, 24'h80B005, 32'h0, 0, 3'h0, 32'h96);
   endtask
   // Main sequence; watchdog allows about 28 times the expected run
   initial begin
      {rst_n_i, strb_i, rd_wr_i, addr_i, wdata_i, switch_i} = '0;
      repeat (20) @(negedge sys_clk_i);
      rst_n_i = 1'h1;
      t_quiet();
      t_ext();
      t_iram();
      t_swled();
      results();
   end
   initial begin
      repeat (3000) @(posedge sys_clk_i);
      error_cnt++;
      results();
   end
endmodule
